// file: src/lfp_regs.svh
// Timing counts and fixed values for the low forward power check
// Assumes a 100 MHz clock and a 1 ms timer tick derived from it
`ifndef LFP_REGS_SVH
`define LFP_REGS_SVH

// Clock rate and timer tick
`define LFP_CLK_HZ 100000000
`define LFP_TICK_US 1000
`define LFP_TICK_CYCLES ((`LFP_CLK_HZ / 1000000) * `LFP_TICK_US)

// Phase shift applied to the AB voltage, in degrees
`define LFP_SHIFT_DEG 30

// Reset values of the delay settings, in ms ticks
`define LFP_PICKUP_RST 16'h07d0
`define LFP_DROPOFF_RST 16'h0000

`endif

// file: src/lfp_pkg.sv
// Types for the low forward power check
// Assumes the constants header is included where counts are needed
package lfp_pkg;
    // Signed sample of a measured quantity
    typedef logic signed [15:0] lfp_sample_t;
    // Single-phase power in secondary watts, scaled
    typedef logic signed [31:0] lfp_power_t;
    // Delay setting in timer ticks
    typedef logic [15:0] lfp_delay_t;
    // Timer states
    typedef enum logic [1:0] {
        lfp_idle,
        lfp_timing,
        lfp_holding,
        lfp_operated
    } lfp_state_e;
endpackage

// file: src/lfp_meas_if.sv
// Carries the power measurement from the element to the timer
// Assumes both ends share one clock
`timescale 1ns/1ns
interface lfp_meas_if;
    logic operate; // Element below threshold
    modport element (output operate);
    modport timer (input operate);
endinterface

// file: src/lfp_element.sv
// Measuring element: single-phase power against the threshold
// Assumes in-phase and quadrature samples arrive together with a strobe
`timescale 1ns/1ns
module lfp_element (
    input wire logic clock,                       // System clock
    input wire logic reset_n,                     // Async reset, active low
    input wire logic sample_valid,                // New samples present
    input wire lfp_pkg::lfp_sample_t phase_ab_voltage_re, // AB voltage, real part
    input wire lfp_pkg::lfp_sample_t phase_ab_voltage_im, // AB voltage, imaginary part
    input wire lfp_pkg::lfp_sample_t current_a_re,  // Sensitive A current, real
    input wire lfp_pkg::lfp_sample_t current_a_im,  // Sensitive A current, imaginary
    input wire lfp_pkg::lfp_power_t threshold,      // Threshold in scaled watts
    lfp_meas_if.element meas                        // Result to the timer
);
    // cos30 and sin30 in Q15; rotation by -30 deg of the AB voltage gives the A voltage direction
    localparam logic signed [16:0] COS30 = 17'sh06eda;
    localparam logic signed [16:0] SIN30 = 17'sh04000;
    localparam logic signed [33:0] INV_SQRT3 = 34'sh0000049e7; // 1/sqrt3 in Q15

    logic signed [33:0] rot_re;
    logic signed [33:0] rot_im;
    logic signed [47:0] dot;
    logic signed [47:0] scaled;
    lfp_pkg::lfp_power_t power;
    logic next_operate;
    logic operate_q;

    // Rotate voltage by -30 deg and form V*I*cos(phi)/sqrt3
    always_comb begin
        rot_re = (phase_ab_voltage_re * COS30) + (phase_ab_voltage_im * SIN30);
        rot_im = (phase_ab_voltage_im * COS30) - (phase_ab_voltage_re * SIN30);
        dot = ((rot_re >>> 15) * current_a_re) + ((rot_im >>> 15) * current_a_im);
        scaled = (dot * INV_SQRT3) >>> 15;
        power = scaled[31:0];
        // Direct comparison in single-phase watts
        next_operate = sample_valid ? (power < threshold) : operate_q;
    end

    // Register the result
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            operate_q <= 1'b0;
        end else begin
            operate_q <= next_operate;
        end
    end

    // Hand the result to the timers
    assign meas.operate = operate_q;
endmodule

// file: src/low_forward_power_element.sv
// Low forward power check: element plus pickup and drop-off timers
// Assumes phasor samples from the measurement front end and settings held outside
// Assumes all inputs are synchronous to the one clock
// Assumes settings stay steady while a timer runs; they are read live
// Delays count 1 ms ticks from a free-running divider inside this block
`timescale 1ns/1ns
`include "lfp_regs.svh"
module low_forward_power_element (
    input wire logic clock,                         // System clock 100 MHz
    input wire logic reset_n,                       // Async reset, active low
    input wire logic sample_valid,                  // New phasor samples
    input wire lfp_pkg::lfp_sample_t phase_ab_voltage_re, // AB voltage real
    input wire lfp_pkg::lfp_sample_t phase_ab_voltage_im, // AB voltage imaginary
    input wire lfp_pkg::lfp_sample_t current_a_re,  // Sensitive A current real
    input wire lfp_pkg::lfp_sample_t current_a_im,  // Sensitive A current imaginary
    input wire lfp_pkg::lfp_power_t threshold,      // Threshold, scaled watts
    input wire lfp_pkg::lfp_delay_t pickup_delay,   // Pickup delay in ms ticks
    input wire lfp_pkg::lfp_delay_t dropoff_delay,  // Reset delay in ms ticks
    input wire logic matrix_enable,                 // Route to logic matrix
    input wire logic contact_enable,                // Route to output contact
    input wire logic non_urgent_trip_req,           // Non-urgent trip request
    output logic element_operated,                  // Raw element state
    output logic power_low,                         // Timed output
    output logic non_urgent_trip,                   // Gated non-urgent trip
    output logic interlock_contact                  // Contact for manual interlock
);
    // ****************************************************************
    // Measuring element
    // ****************************************************************
    // Carrier from the element to the timers
    lfp_meas_if meas ();

    // Power against threshold, registered on each new sample
    // The element holds its result between samples
    lfp_element u_element (
        .clock(clock),
        .reset_n(reset_n),
        .sample_valid(sample_valid),
        .phase_ab_voltage_re(phase_ab_voltage_re),
        .phase_ab_voltage_im(phase_ab_voltage_im),
        .current_a_re(current_a_re),
        .current_a_im(current_a_im),
        .threshold(threshold),
        .meas(meas)
    );

    // ****************************************************************
    // Millisecond tick
    // ****************************************************************
    // Terminal count of the 1 ms divider
    localparam logic [16:0] TICK_MAX = 17'(`LFP_TICK_CYCLES - 1);
    logic [16:0] tick_cnt;
    logic [16:0] next_tick_cnt;
    logic tick;

    // Free-running divider giving a one-cycle tick
    // The divider never stops, so delays are counted in whole ticks
    // A timer may start just before a tick, so its first tick can come early
    // and a delay of N ticks runs for between N-1 and N ms
    always_comb begin
        tick = (tick_cnt == TICK_MAX);
        next_tick_cnt = tick ? 17'h00000 : tick_cnt + 17'h00001;
    end

    // Register the divider
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            tick_cnt <= 17'h00000;
        end else begin
            tick_cnt <= next_tick_cnt;
        end
    end

    // ****************************************************************
    // Pickup and drop-off timers
    // ****************************************************************
    // The pickup count is kept through a dropout and only cleared once the
    // element has stayed dropped for the whole reset delay
    // Counts are in ticks; the output register feeds all routing
    lfp_pkg::lfp_state_e state;
    lfp_pkg::lfp_state_e next_state;
    lfp_pkg::lfp_delay_t pick_cnt;
    lfp_pkg::lfp_delay_t next_pick_cnt;
    lfp_pkg::lfp_delay_t drop_cnt;
    lfp_pkg::lfp_delay_t next_drop_cnt;
    logic out_q;
    logic next_out;

    // True once a count has reached its setting; a zero setting expires at once
    function automatic logic lfp_expired(input lfp_pkg::lfp_delay_t count, input lfp_pkg::lfp_delay_t limit);
        lfp_expired = (count >= limit);
    endfunction

    // Timer sequencing on element state and the tick
    always_comb begin
        next_state = state;
        next_pick_cnt = pick_cnt;
        next_drop_cnt = drop_cnt;
        next_out = out_q;
        // Idle to timing to operated on pickup, idle straight to operated with zero pickup; timing or operated to holding on dropout;
        // holding back to timing on re-operate, or to idle once the reset delay has run out
        case (state)
            // Wait for the element to operate
            lfp_pkg::lfp_idle: begin
                next_out = 1'b0;
                if (meas.operate) begin
                    if (pickup_delay == 16'h0000) begin
                        next_state = lfp_pkg::lfp_operated;
                        next_out = 1'b1;
                    end else begin
                        next_state = lfp_pkg::lfp_timing;
                        next_pick_cnt = 16'h0000;
                    end
                end
            end

            // Count ticks while the element stays operated
            lfp_pkg::lfp_timing: begin
                if (!meas.operate) begin
                    next_state = lfp_pkg::lfp_holding; // Keep accumulated time
                    next_drop_cnt = 16'h0000;
                end else if (lfp_expired(pick_cnt, pickup_delay)) begin
                    next_state = lfp_pkg::lfp_operated;
                    next_out = 1'b1;
                end else if (tick) begin
                    next_pick_cnt = pick_cnt + 16'h0001;
                end
            end

            // Hold the pickup count and count the reset delay
            lfp_pkg::lfp_holding: begin
                if (meas.operate) begin
                    next_state = lfp_pkg::lfp_timing; // Resume from held time
                end else if (lfp_expired(drop_cnt, dropoff_delay)) begin
                    next_state = lfp_pkg::lfp_idle; // Clear after full reset delay
                    next_pick_cnt = 16'h0000;
                    next_out = 1'b0;
                end else if (tick) begin
                    next_drop_cnt = drop_cnt + 16'h0001;
                end
            end

            // Output stands through a dropout until the reset delay runs out
            lfp_pkg::lfp_operated: begin
                next_out = 1'b1;
                if (!meas.operate) begin
                    next_state = lfp_pkg::lfp_holding; // Output stays until reset delay ends
                    next_drop_cnt = 16'h0000;
                end
            end
            // Default falls back to idle; all four encodings are in use
            default: begin
                next_state = lfp_pkg::lfp_idle;
                next_out = 1'b0;
            end
        endcase
    end

    // Register timer state, counts and output
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state <= lfp_pkg::lfp_idle;
            pick_cnt <= 16'h0000;
            drop_cnt <= 16'h0000;
            out_q <= 1'b0;
        end else begin
            state <= next_state;
            pick_cnt <= next_pick_cnt;
            drop_cnt <= next_drop_cnt;
            out_q <= next_out;
        end
    end

    // ****************************************************************
    // Output routing
    // ****************************************************************
    // Registered routed outputs
    logic trip_q;
    logic contact_q;
    logic next_trip;
    logic next_contact;

    // Permissive gating and contact drive
    // With matrix_enable low the permissive is not applied and trips pass
    // Both outputs are registered so that a relay sees no glitches
    always_comb begin
        next_trip = non_urgent_trip_req & (~matrix_enable | out_q);
        next_contact = contact_enable & out_q;
    end

    // Register the routed outputs
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            trip_q <= 1'b0;
            contact_q <= 1'b0;
        end else begin
            trip_q <= next_trip;
            contact_q <= next_contact;
        end
    end

    // ****************************************************************
    // Port drive
    // ****************************************************************
    // element_operated is the raw element, power_low the timed output
    // non_urgent_trip passes the request only while the timed output is high, when gated
    // interlock_contact follows the timed output, when the contact is enabled
    // Drive the ports
    assign element_operated = meas.operate;
    assign power_low = out_q;
    assign non_urgent_trip = trip_q;
    assign interlock_contact = contact_q;
endmodule

// file: bench/lfp_props.sv
// Checker for the low forward power check outputs
// Bound to the top module; sees its ports only
`timescale 1ns/1ns
module lfp_props (
    input wire logic clock, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic sample_valid, // New samples
    input wire lfp_pkg::lfp_delay_t pickup_delay, // Pickup delay
    input wire lfp_pkg::lfp_delay_t dropoff_delay, // Reset delay
    input wire logic matrix_enable, // Gate trips
    input wire logic contact_enable, // Drive contact
    input wire logic non_urgent_trip_req, // Trip request
    input wire logic element_operated, // Raw element
    input wire logic power_low, // Timed output
    input wire logic non_urgent_trip, // Gated trip
    input wire logic interlock_contact // Contact
);
    // ****************
    // Assertions
    // ****************
    default clocking dc @(posedge clock); endclocking
    default disable iff (!reset_n);
    a_contact_follows: assert property (
        $past(reset_n) |-> interlock_contact == ($past(contact_enable) & $past(power_low)))
        else $error("contact does not follow timed output");
    a_trip_gated: assert property (
        $past(reset_n) |->
        non_urgent_trip == ($past(non_urgent_trip_req) & (!$past(matrix_enable) | $past(power_low))))
        else $error("trip gating wrong");
    a_pickup_zero: assert property (
        ($rose(element_operated) && pickup_delay == 16'h0000) |-> ##[1:2] power_low)
        else $error("no immediate output with zero pickup");
    a_dropout_zero: assert property (
        ($fell(element_operated) && dropoff_delay == 16'h0000) ##1 !element_operated |-> ##[0:1] !power_low)
        else $error("output kept after zero reset delay");
    a_rise_cause: assert property ($rose(power_low) |-> $past(element_operated))
        else $error("output rose without element");
    a_fall_cause: assert property ($fell(power_low) |-> !$past(element_operated))
        else $error("output fell while element operated");
    a_hold_operated: assert property (element_operated && power_low |=> power_low)
        else $error("output dropped while operated");
    a_element_sampled: assert property (!sample_valid |=> $stable(element_operated))
        else $error("element changed without sample");
    c_low: cover property ($rose(power_low));
    c_contact: cover property (interlock_contact);
    c_gated: cover property (non_urgent_trip && matrix_enable);
endmodule
bind low_forward_power_element lfp_props u_props (.clock(clock), .reset_n(reset_n), .sample_valid(sample_valid),
    .pickup_delay(pickup_delay), .dropoff_delay(dropoff_delay), .matrix_enable(matrix_enable),
    .contact_enable(contact_enable), .non_urgent_trip_req(non_urgent_trip_req), .element_operated(element_operated),
    .power_low(power_low), .non_urgent_trip(non_urgent_trip), .interlock_contact(interlock_contact));

// file: bench/lfp_meas_src.sv
// Model of the CT and VT front end delivering phasor samples
// Assumes the bench requests each sample with a one-cycle load strobe
`timescale 1ns/1ns
module lfp_meas_src (
    input wire logic clock, // System clock
    input wire logic reset_n, // Async reset, active low
    input wire logic load, // Request a sample
    input wire logic [63:0] set_q, // V re, V im, I re, I im
    output logic sample_valid, // Sample present
    output logic [63:0] smp // Phasor lines
);
    // Presents the AB voltage and A current pair for one cycle, then scrambles the lines
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            sample_valid <= 1'b0;
            smp <= 64'h0;
        end else begin
            sample_valid <= load;
            smp <= load ? set_q : ~smp;
        end
    end
endmodule

// file: bench/low_forward_power_element_tb.sv
// Testbench for the low forward power check
// Assumes design sources, checker and sample model are compiled first
`timescale 1ns/1ns
module low_forward_power_element_tb;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic load = 1'b0;
    logic [63:0] set_q = 64'h0;
    logic [63:0] smp;
    logic sample_valid;
    lfp_pkg::lfp_power_t threshold = 32'h0;
    lfp_pkg::lfp_delay_t pickup_delay = 16'h0001; // One tick stands in for the usual 2 s
    lfp_pkg::lfp_delay_t dropoff_delay = 16'h0000;
    logic matrix_enable = 1'b0, contact_enable = 1'b0, non_urgent_trip_req = 1'b0;
    logic element_operated, power_low, non_urgent_trip, interlock_contact;
    logic [3:0] outs;
    logic [3:0] notes [$];
    logic [4:0] vd = 5'h00;
    int miscompares = 0;
    int comparisons = 0;
    assign outs = {element_operated, power_low, non_urgent_trip, interlock_contact};
    // Clock at 100 MHz
    always #5 clock = ~clock;
    lfp_meas_src src (.clock(clock), .reset_n(reset_n), .load(load), .set_q(set_q), .sample_valid(sample_valid),
        .smp(smp));
    low_forward_power_element uut (.clock(clock), .reset_n(reset_n), .sample_valid(sample_valid),
        .phase_ab_voltage_re(smp[63:48]), .phase_ab_voltage_im(smp[47:32]), .current_a_re(smp[31:16]),
        .current_a_im(smp[15:0]), .threshold(threshold), .pickup_delay(pickup_delay), .dropoff_delay(dropoff_delay),
        .matrix_enable(matrix_enable), .contact_enable(contact_enable), .non_urgent_trip_req(non_urgent_trip_req),
        .element_operated(element_operated), .power_low(power_low), .non_urgent_trip(non_urgent_trip),
        .interlock_contact(interlock_contact));
    // ****************
    // Tasks
    // ****************
    task automatic give_verdict();
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: expected %h, got %h", $time, exp, got);
        end
    endtask
    // One sample with random routing; notes the expected outputs, held marks a running reset delay
    task automatic step(input logic [63:0] s, input logic [31:0] thr, input logic op, input logic held);
        logic me, ce, rq, low;
        me = 1'($urandom);
        ce = 1'($urandom);
        rq = 1'($urandom);
        @(posedge clock);
        set_q <= s;
        threshold <= thr;
        load <= 1'b1;
        matrix_enable <= me;
        contact_enable <= ce;
        non_urgent_trip_req <= rq; // Non-urgent request only
        low = (op & (pickup_delay == 16'h0000)) | held;
        notes.push_back({op, low, rq & (~me | low), ce & low});
        @(posedge clock);
        load <= 1'b0;
        repeat (9) @(posedge clock);
    endtask
    // Random phasors kept clear of the zero-power boundary
    task automatic rnd_step();
        int r[4];
        real p;
        do begin
            foreach (r[k]) begin
                r[k] = int'($urandom % 32'd32001) - 16000;
            end
            p = (r[0] * r[2] + r[1] * r[3]) * 0.8660254 + (r[1] * r[2] - r[0] * r[3]) * 0.5;
        end while (p < 1.0e7 && p > -1.0e7);
        step({16'(r[0]), 16'(r[1]), 16'(r[2]), 16'(r[3])}, 32'h0, p < 0.0, 1'b0);
    endtask
    // Compares outputs five edges after each accepted sample
    always @(posedge clock) begin
        vd <= {vd[3:0], sample_valid};
        if (vd[4] && notes.size() > 0) begin
            check(notes.pop_front(), outs);
        end
    end
    // Pickup of one tick first, then zero pickup
    initial begin
        void'($urandom(32'h675b));
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        for (int ph = 0; ph < 2; ph++) begin
            step(64'h0, 32'h1, 1'b1, 1'b0); // Small threshold
            step(64'h0, 32'h0, 1'b0, 1'b0);
            repeat (10 + 30 * ph) rnd_step();
            step(64'h2710_0000_2710_0000, 32'h0, 1'b0, 1'b0);
            pickup_delay <= 16'h0000;
        end
        // Reset delay of one tick keeps the output through a dropout, then zero clears it
        dropoff_delay <= 16'h0001;
        step(64'h0, 32'h1, 1'b1, 1'b0);
        step(64'h0, 32'h0, 1'b0, 1'b1);
        dropoff_delay <= 16'h0000;
        step(64'h0, 32'h0, 1'b0, 1'b0);
        repeat (12) @(posedge clock);
        give_verdict();
    end
    // Watchdog
    initial begin
        #100000;
        miscompares++;
        give_verdict();
    end
endmodule
